// ==== rtl/cdtc_pkg.sv ====
// ************************************************************
// Shared constants for the cascadable dual timer
// ************************************************************
package cdtc_pkg;
    // Bus and prescaler widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int PRE_W = 11;
    // Register offsets
    localparam logic [7:0] OFF_CTL_A = 8'h27;
    localparam logic [7:0] OFF_CTL_B = 8'h28;
    localparam logic [7:0] OFF_MATCH_A = 8'h29;
    localparam logic [7:0] OFF_PW_A = 8'h2A;
    localparam logic [7:0] OFF_MATCH_B = 8'h2B;
    localparam logic [7:0] OFF_PW_B = 8'h2C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h2D;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h2E;
    localparam logic [7:0] OFF_OPTION = 8'h2F;
    // Reset value of every register
    localparam logic [7:0] REG_RESET = 8'h00;
    // Control register field positions
    localparam int FF_BIT = 7;
    localparam int CS_HI = 6;
    localparam int CS_LO = 4;
    localparam int RUN_BIT = 3;
    localparam int MODE_HI = 2;
    localparam int MODE_LO = 0;
    // Interrupt status and option bit positions
    localparam int IRQ_A = 0;
    localparam int IRQ_B = 1;
    localparam int OPT_DIV_LOW = 0;
    localparam int OPT_LOW_SPEED = 1;
    // Clock select codes
    localparam logic [2:0] CS_DIV2048 = 3'h0;
    localparam logic [2:0] CS_DIV128 = 3'h1;
    localparam logic [2:0] CS_DIV32 = 3'h2;
    localparam logic [2:0] CS_DIV8 = 3'h3;
    localparam logic [2:0] CS_LOW = 3'h4;
    localparam logic [2:0] CS_DIV2 = 3'h5;
    localparam logic [2:0] CS_HIGH = 3'h6;
    localparam logic [2:0] CS_PIN = 3'h7;
    // Prescaler tap masks and divider constants
    localparam logic [10:0] TAP_DIV2 = 11'h001;
    localparam logic [10:0] TAP_DIV8 = 11'h007;
    localparam logic [10:0] TAP_DIV32 = 11'h01F;
    localparam logic [10:0] TAP_DIV128 = 11'h07F;
    localparam logic [10:0] TAP_DIV2048 = 11'h7FF;
    localparam logic [10:0] PRE_ONE = 11'h001;
    localparam logic [2:0] LOW_DIV_LAST = 3'h7;
    localparam logic [2:0] LOW_DIV_ONE = 3'h1;
    // Mode codes
    localparam logic [2:0] MODE_TIMER = 3'h0;
    localparam logic [2:0] MODE_DIVOUT = 3'h1;
    localparam logic [2:0] MODE_PWM8 = 3'h2;
    localparam logic [2:0] MODE_A_CASCADE = 3'h3;
    localparam logic [2:0] MODE_B_RESERVED = 3'h3;
    localparam logic [2:0] MODE_B_T16 = 3'h4;
    localparam logic [2:0] MODE_B_WARMUP = 3'h5;
    localparam logic [2:0] MODE_B_PWM16 = 3'h6;
    localparam logic [2:0] MODE_B_PULSEGEN = 3'h7;
    // Counter constants
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [15:0] CNT16_ONE = 16'h0001;
endpackage

// ==== rtl/cdtc_timer.sv ====
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module cdtc_timer (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [cdtc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [cdtc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [cdtc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic low_freq_clock,
    input wire logic ext_count_a,
    input wire logic ext_count_b,
    output logic timer_match_irq,
    output logic timer_a_ff_out,
    output logic timer_b_ff_out
);
    import cdtc_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0] timer_a_control;     // Unit A control
        logic [7:0] timer_b_control;     // Unit B control
        logic [7:0] timer_a_match_value; // Unit A period
        logic [7:0] timer_a_pulse_width; // Unit A pulse width
        logic [7:0] timer_b_match_value; // Unit B period
        logic [7:0] timer_b_pulse_width; // Unit B pulse width
        logic [1:0] irq_stat;            // Sticky events
        logic [1:0] irq_mask;            // Interrupt enables
        logic [1:0] option;              // Divider option, low speed
        logic [7:0] cnt_a;               // Unit A up-counter
        logic [7:0] cnt_b;               // Unit B up-counter
        logic [10:0] pre;                // High clock prescaler
        logic [2:0] low_div;             // Low clock divide by eight
        logic [1:0] low_sync;            // Low clock synchroniser
        logic low_prev;                  // Low clock edge history
        logic [1:0] pin_a_sync;          // Pin A synchroniser
        logic pin_a_prev;                // Pin A edge history
        logic [1:0] pin_b_sync;          // Pin B synchroniser
        logic pin_b_prev;                // Pin B edge history
        logic [7:0] rdata;               // Read data
        logic irq;                       // Interrupt output
        logic ff_a;                      // Unit A flip-flop
        logic ff_b;                      // Unit B flip-flop
    } cdtc_state_t;

    cdtc_state_t s_r;
    cdtc_state_t s_nxt;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Prescaler tap fires when the low bits are all ones
    function automatic logic cdtc_tap(input logic [10:0] pre, input logic [10:0] mask);
        cdtc_tap = ((pre & mask) == mask);
    endfunction

    // Source clock enable for one unit
    function automatic logic cdtc_src(input logic [2:0] cs, input logic [10:0] pre, input logic slow,
                                      input logic low_t, input logic low8_t, input logic pin_t);
        case (cs)
            CS_DIV2048: cdtc_src = slow ? low8_t : cdtc_tap(pre, TAP_DIV2048);
            CS_DIV128: cdtc_src = cdtc_tap(pre, TAP_DIV128);
            CS_DIV32: cdtc_src = cdtc_tap(pre, TAP_DIV32);
            CS_DIV8: cdtc_src = cdtc_tap(pre, TAP_DIV8);
            CS_LOW: cdtc_src = low_t;
            CS_DIV2: cdtc_src = cdtc_tap(pre, TAP_DIV2);
            CS_HIGH: cdtc_src = 1'b1;
            CS_PIN: cdtc_src = pin_t;
            default: cdtc_src = 1'b0;
        endcase
    endfunction

    // Register read multiplexer
    function automatic logic [7:0] cdtc_read(input cdtc_state_t s, input logic [7:0] addr);
        case (addr)
            OFF_CTL_A: cdtc_read = s.timer_a_control;
            OFF_CTL_B: cdtc_read = s.timer_b_control;
            OFF_MATCH_A: cdtc_read = s.timer_a_match_value;
            OFF_PW_A: cdtc_read = s.timer_a_pulse_width;
            OFF_MATCH_B: cdtc_read = s.timer_b_match_value;
            OFF_PW_B: cdtc_read = s.timer_b_pulse_width;
            OFF_IRQ_STAT: cdtc_read = {6'h00, s.irq_stat};
            OFF_IRQ_MASK: cdtc_read = {6'h00, s.irq_mask};
            OFF_OPTION: cdtc_read = {6'h00, s.option};
            default: cdtc_read = REG_RESET;
        endcase
    endfunction

    // ************************************************************
    // Decoded controls
    // ************************************************************
    logic low_t;        // Low clock rising edge
    logic low8_t;       // Low clock divided by eight
    logic pin_a_t;      // Pin A rising edge
    logic pin_b_t;      // Pin B rising edge
    logic slow;         // Code 000 uses the low clock
    logic tick_a;       // Unit A source enable
    logic tick_b;       // Unit B source enable
    logic cascade;      // 16-bit operation active
    logic run_a;        // Unit A counting
    logic run_b;        // Unit B counting
    logic [7:0] inc_a;  // Unit A next count
    logic [7:0] inc_b;  // Unit B next count
    logic [15:0] inc16; // Cascaded next count
    logic ev_a;         // Unit A match
    logic ev_b;         // Unit B or 16-bit match
    logic wr_ctl_a;     // Write to control A
    logic wr_ctl_b;     // Write to control B

    // ************************************************************
    // Next state
    // ************************************************************
    // All sequential behaviour is computed here
    always_comb
    begin
        s_nxt = s_r;
        // Synchronisers, first stage read only by the second
        s_nxt.low_sync = {s_r.low_sync[0], low_freq_clock};
        s_nxt.low_prev = s_r.low_sync[1];
        s_nxt.pin_a_sync = {s_r.pin_a_sync[0], ext_count_a};
        s_nxt.pin_a_prev = s_r.pin_a_sync[1];
        s_nxt.pin_b_sync = {s_r.pin_b_sync[0], ext_count_b};
        s_nxt.pin_b_prev = s_r.pin_b_sync[1];
        low_t = s_r.low_sync[1] & ~s_r.low_prev;
        pin_a_t = s_r.pin_a_sync[1] & ~s_r.pin_a_prev;
        pin_b_t = s_r.pin_b_sync[1] & ~s_r.pin_b_prev;
        // Prescalers
        s_nxt.pre = s_r.pre + PRE_ONE;
        low8_t = low_t && (s_r.low_div == LOW_DIV_LAST);
        if (low_t)
        begin
            s_nxt.low_div = s_r.low_div + LOW_DIV_ONE;
        end
        slow = s_r.option[OPT_DIV_LOW] | s_r.option[OPT_LOW_SPEED];
        // Source clock selection per unit
        tick_a = cdtc_src(s_r.timer_a_control[CS_HI:CS_LO], s_r.pre, slow, low_t, low8_t, pin_a_t);
        tick_b = cdtc_src(s_r.timer_b_control[CS_HI:CS_LO], s_r.pre, slow, low_t, low8_t, pin_b_t);
        // Cascade needs both halves programmed for it
        cascade = s_r.timer_b_control[MODE_HI] &&
                  (s_r.timer_a_control[MODE_HI:MODE_LO] == MODE_A_CASCADE);
        // In cascade the run bit of unit B governs both halves
        run_a = cascade ? s_r.timer_b_control[RUN_BIT] : s_r.timer_a_control[RUN_BIT];
        run_b = s_r.timer_b_control[RUN_BIT];
        inc_a = s_r.cnt_a + CNT_ONE;
        inc_b = s_r.cnt_b + CNT_ONE;
        inc16 = {s_r.cnt_b, s_r.cnt_a} + CNT16_ONE;
        ev_a = 1'b0;
        ev_b = 1'b0;
        // Counting
        if (cascade)
        begin
            // Carry out of unit A clocks unit B, whatever B selects
            if (!run_a)
            begin
                s_nxt.cnt_a = CNT_ZERO;
                s_nxt.cnt_b = CNT_ZERO;
            end
            else if (tick_a)
            begin
                ev_b = (inc16 == {s_r.timer_b_match_value, s_r.timer_a_match_value});
                {s_nxt.cnt_b, s_nxt.cnt_a} = ev_b ? {CNT_ZERO, CNT_ZERO} : inc16;
            end
        end
        else
        begin
            // Unit A alone, every 8-bit mode counts to its match
            if (!run_a)
            begin
                s_nxt.cnt_a = CNT_ZERO;
            end
            else if (tick_a)
            begin
                ev_a = (inc_a == s_r.timer_a_match_value);
                s_nxt.cnt_a = ev_a ? CNT_ZERO : inc_a;
            end
            // Unit B alone; reserved and unpaired 16-bit codes hold
            if (!run_b)
            begin
                s_nxt.cnt_b = CNT_ZERO;
            end
            else if (tick_b && (s_r.timer_b_control[MODE_HI:MODE_LO] < MODE_B_RESERVED))
            begin
                ev_b = (inc_b == s_r.timer_b_match_value);
                s_nxt.cnt_b = ev_b ? CNT_ZERO : inc_b;
            end
        end
        // Register writes
        wr_ctl_a = reg_wr && (reg_addr == OFF_CTL_A);
        wr_ctl_b = reg_wr && (reg_addr == OFF_CTL_B);
        if (wr_ctl_a)
        begin
            s_nxt.timer_a_control = reg_wdata;
            s_nxt.ff_a = reg_wdata[FF_BIT];
        end
        if (wr_ctl_b)
        begin
            s_nxt.timer_b_control = reg_wdata;
            s_nxt.ff_b = reg_wdata[FF_BIT];
        end
        if (reg_wr)
        begin
            case (reg_addr)
                OFF_MATCH_A: s_nxt.timer_a_match_value = reg_wdata;
                OFF_PW_A: s_nxt.timer_a_pulse_width = reg_wdata;
                OFF_MATCH_B: s_nxt.timer_b_match_value = reg_wdata;
                OFF_PW_B: s_nxt.timer_b_pulse_width = reg_wdata;
                OFF_IRQ_MASK: s_nxt.irq_mask = reg_wdata[1:0];
                OFF_OPTION: s_nxt.option = reg_wdata[1:0];
                default: s_nxt.irq_mask = s_r.irq_mask;
            endcase
        end
        // Sticky status: write one clears, a new event wins
        if (reg_wr && (reg_addr == OFF_IRQ_STAT))
        begin
            s_nxt.irq_stat = s_r.irq_stat & ~reg_wdata[1:0];
        end
        s_nxt.irq_stat[IRQ_A] = s_nxt.irq_stat[IRQ_A] | ev_a;
        s_nxt.irq_stat[IRQ_B] = s_nxt.irq_stat[IRQ_B] | ev_b;
        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
        // Read data stands for one cycle only
        s_nxt.rdata = reg_rd ? cdtc_read(s_r, reg_addr) : REG_RESET;
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Asynchronous reset clears everything
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs come straight from flip-flops
    assign reg_rdata = s_r.rdata;
    assign timer_match_irq = s_r.irq;
    assign timer_a_ff_out = s_r.ff_a;
    assign timer_b_ff_out = s_r.ff_b;

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_rd_ctl_a;
        reg_rd && (reg_addr == OFF_CTL_A);
    endsequence

    sequence s_wr_ctl_a;
        reg_wr && (reg_addr == OFF_CTL_A);
    endsequence

    property p_ctl_readback;
        @(posedge sys_clk) disable iff (!resetn)
        s_rd_ctl_a |=> (reg_rdata == $past(s_r.timer_a_control));
    endproperty
    a_ctl_readback: assert property (p_ctl_readback) else $error("control read mismatch");

    property p_ctl_write;
        @(posedge sys_clk) disable iff (!resetn)
        s_wr_ctl_a |=> (s_r.timer_a_control == $past(reg_wdata));
    endproperty
    a_ctl_write: assert property (p_ctl_write) else $error("control write lost");

    property p_ff_write;
        @(posedge sys_clk) disable iff (!resetn)
        reg_wr && (reg_addr == OFF_CTL_B) |=> (timer_b_ff_out == $past(reg_wdata[FF_BIT]));
    endproperty
    a_ff_write: assert property (p_ff_write) else $error("flip-flop output wrong");

    property p_stop_clears;
        @(posedge sys_clk) disable iff (!resetn)
        !run_a ##1 !run_a |-> (s_r.cnt_a == CNT_ZERO);
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("stopped counter not zero");

    property p_match_irq;
        @(posedge sys_clk) disable iff (!resetn)
        ev_a |=> s_r.irq_stat[IRQ_A] && (s_r.cnt_a == CNT_ZERO);
    endproperty
    a_match_irq: assert property (p_match_irq) else $error("match did not flag and clear");

    property p_fast_count;
        @(posedge sys_clk) disable iff (!resetn)
        !cascade && run_a && !ev_a && !wr_ctl_a && (s_r.timer_a_control[CS_HI:CS_LO] == CS_HIGH)
        |=> (s_r.cnt_a == $past(inc_a));
    endproperty
    a_fast_count: assert property (p_fast_count) else $error("undivided clock not counting");

    property p_b_holds_in_cascade;
        @(posedge sys_clk) disable iff (!resetn)
        cascade && run_b && !ev_b && (s_r.cnt_a != 8'hFF) |=> (s_r.cnt_b == $past(s_r.cnt_b));
    endproperty
    a_b_holds_in_cascade: assert property (p_b_holds_in_cascade) else $error("upper half moved");

    property p_cascade_run;
        @(posedge sys_clk) disable iff (!resetn)
        cascade && !s_r.timer_b_control[RUN_BIT] |=> (s_r.cnt_a == CNT_ZERO);
    endproperty
    a_cascade_run: assert property (p_cascade_run) else $error("lower half ran without B run");

    property p_irq_level;
        @(posedge sys_clk) disable iff (!resetn)
        timer_match_irq == |(s_r.irq_stat & s_r.irq_mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

    property p_rdata_one_cycle;
        @(posedge sys_clk) disable iff (!resetn)
        !reg_rd |=> (reg_rdata == REG_RESET);
    endproperty
    a_rdata_one_cycle: assert property (p_rdata_one_cycle) else $error("read data lingered");
endmodule

// ==== verif/tb_cascadable_dual_8bit_timer_control.sv ====
`timescale 1ns/1ps
module tb_cascadable_dual_8bit_timer_control;
    import cdtc_pkg::*;
    // ************************************************************
    // Stimulus signals and bookkeeping
    // ************************************************************
    logic sys_clk = 1'b0; // 100 MHz clock
    logic resetn = 1'b0; // Active low reset
    logic [7:0] reg_addr = 8'h00; // Register offset
    logic [7:0] reg_wdata = 8'h00; // Write data
    logic reg_wr = 1'b0; // Write strobe
    logic reg_rd = 1'b0; // Read strobe
    logic [7:0] reg_rdata; // Read data
    logic low_freq_clock = 1'b0; // Slow clock pin, period 20 cycles
    logic ext_count_a = 1'b0; // Count pin A, period 10 cycles
    logic ext_count_b = 1'b0; // Count pin B, period 12 cycles
    logic timer_match_irq; // Interrupt output
    logic timer_a_ff_out; // Unit A flip-flop state
    logic timer_b_ff_out; // Unit B flip-flop state
    int miscompares = 0; // Mismatch count
    int total_checks = 0; // Comparison count
    int cyc = 0; // Free cycle counter
    int t1; // First event time
    int t2; // Second event time
    logic [7:0] rd_v; // Last read value

    cdtc_timer cdtc_timer_inst (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .low_freq_clock(low_freq_clock),
        .ext_count_a(ext_count_a),
        .ext_count_b(ext_count_b),
        .timer_match_irq(timer_match_irq),
        .timer_a_ff_out(timer_a_ff_out),
        .timer_b_ff_out(timer_b_ff_out)
    );

    // ************************************************************
    // Clock, slow clock, count pins and hang guard
    // ************************************************************
    // Main clock
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end
    // Steady pin waveforms keep tick spacing exact; the guard ends a hang
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc % 10 == 9) low_freq_clock <= ~low_freq_clock;
        if (cyc % 5 == 4) ext_count_a <= ~ext_count_a;
        if (cyc % 6 == 5) ext_count_b <= ~ext_count_b;
        if (cyc >= 90000)
        begin
            miscompares = miscompares + 1;
            wrap_up();
        end
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    // Compare and report
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One-cycle write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // One-cycle read, data taken in the following cycle
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask
    // Wait for the interrupt level under a bound, return the cycle seen
    task automatic wait_irq(input logic lvl, output int t);
        int n;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            #1 n++;
        end while (timer_match_irq !== lvl && n < 20000);
        if (n >= 20000) check(16'h0000, 16'h0001);
        t = cyc;
    endtask
    // Start a unit, time two events, then stop it with unchanged fields
    task automatic measure(input logic u, input logic [2:0] cs, input logic [7:0] opt,
                           input logic [7:0] m, input int exp);
        logic [7:0] ctl;
        ctl = u ? OFF_CTL_B : OFF_CTL_A;
        wr(OFF_OPTION, opt);
        wr(u ? OFF_MATCH_B : OFF_MATCH_A, m);
        wr(OFF_IRQ_MASK, u ? 8'h02 : 8'h01);
        wr(ctl, {1'b0, cs, 1'b1, 3'h0});
        wait_irq(1'b1, t1);
        wr(OFF_IRQ_STAT, 8'h03);
        wait_irq(1'b0, t2);
        wait_irq(1'b1, t2);
        check(16'(t2 - t1), 16'(exp));
        wr(ctl, {1'b0, cs, 1'b0, 3'h0});
        wr(OFF_IRQ_STAT, 8'h03);
        wait_irq(1'b0, t2);
    endtask
    // Final report and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        // Reset state of controls and outputs
        rd(OFF_CTL_A);
        check(16'(rd_v), 16'h0000);
        rd(OFF_CTL_B);
        check(16'(rd_v), 16'h0000);
        check(16'({timer_match_irq, timer_a_ff_out, timer_b_ff_out}), 16'h0000);
        // Control fields read back, flip-flop follows bit 7
        wr(OFF_CTL_A, 8'hA5);
        rd(OFF_CTL_A);
        check(16'(rd_v), 16'h00A5);
        check(16'(timer_a_ff_out), 16'h0001);
        wr(OFF_CTL_B, 8'hD7);
        rd(OFF_CTL_B);
        check(16'(rd_v), 16'h00D7);
        check(16'(timer_b_ff_out), 16'h0001);
        wr(OFF_CTL_A, 8'h00);
        wr(OFF_CTL_B, 8'h00);
        #1 check(16'({timer_a_ff_out, timer_b_ff_out}), 16'h0000);
        // Compare registers hold what was written
        for (int i = 0; i < 4; i++)
        begin
            wr(OFF_MATCH_A + 8'(i), 8'h3C + 8'(i));
            rd(OFF_MATCH_A + 8'(i));
            check(16'(rd_v), 16'h003C + 16'(i));
        end
        // Unmapped place reads zero and ignores writes
        wr(8'h30, 8'hFF);
        rd(8'h30);
        check(16'(rd_v), 16'h0000);
        rd(OFF_CTL_A);
        check(16'(rd_v), 16'h0000);
        // Masked event sets status but not the output
        wr(OFF_MATCH_A, 8'h04);
        wr(OFF_CTL_A, 8'h68);
        repeat (20) @(posedge sys_clk);
        #1 check(16'(timer_match_irq), 16'h0000);
        wr(OFF_CTL_A, 8'h60);
        rd(OFF_IRQ_STAT);
        check(16'(rd_v), 16'h0001);
        wr(OFF_IRQ_STAT, 8'h01);
        rd(OFF_IRQ_STAT);
        check(16'(rd_v), 16'h0000);
        // Stopping clears the counter: restart needs a full period
        wr(OFF_MATCH_A, 8'h14);
        wr(OFF_IRQ_MASK, 8'h01);
        wr(OFF_CTL_A, 8'h68);
        repeat (10) @(posedge sys_clk);
        wr(OFF_CTL_A, 8'h60);
        wr(OFF_CTL_A, 8'h68);
        t1 = cyc;
        wait_irq(1'b1, t2);
        check(16'((t2 - t1) >= 18 && (t2 - t1) <= 23), 16'h0001);
        wr(OFF_CTL_A, 8'h60);
        wr(OFF_IRQ_STAT, 8'h03);
        // Every clock source, one period each; match period is match ticks, 256 ticks for match zero
        measure(1'b0, CS_HIGH, 8'h00, 8'h04, 4);
        measure(1'b0, CS_DIV2, 8'h00, 8'h04, 8);
        measure(1'b0, CS_DIV8, 8'h00, 8'h04, 32);
        measure(1'b0, CS_DIV32, 8'h00, 8'h04, 128);
        measure(1'b0, CS_DIV128, 8'h00, 8'h02, 256);
        measure(1'b0, CS_DIV2048, 8'h00, 8'h02, 4096);
        measure(1'b0, CS_LOW, 8'h00, 8'h03, 60);
        measure(1'b0, CS_DIV2048, 8'h01, 8'h02, 320);
        measure(1'b0, CS_PIN, 8'h00, 8'h03, 30);
        measure(1'b1, CS_HIGH, 8'h00, 8'h05, 5);
        measure(1'b1, CS_PIN, 8'h00, 8'h03, 36);
        measure(1'b1, CS_DIV2048, 8'h02, 8'h02, 320);
        measure(1'b0, CS_HIGH, 8'h00, 8'h00, 256);
        wr(OFF_OPTION, 8'h00);
        // Unit B holds in reserved code and in 16-bit code without cascade
        wr(OFF_MATCH_B, 8'h02);
        wr(OFF_IRQ_MASK, 8'h02);
        wr(OFF_CTL_B, 8'h6B);
        repeat (50) @(posedge sys_clk);
        #1 check(16'(timer_match_irq), 16'h0000);
        wr(OFF_CTL_B, 8'h63);
        wr(OFF_CTL_B, 8'h6C);
        repeat (50) @(posedge sys_clk);
        #1 check(16'(timer_match_irq), 16'h0000);
        wr(OFF_CTL_B, 8'h64);
        // Cascade: A clock select, B run and flip-flop, B counts A overflow
        wr(OFF_MATCH_A, 8'h04);
        wr(OFF_MATCH_B, 8'h01);
        wr(OFF_CTL_A, 8'h63);
        wr(OFF_CTL_B, 8'h9C);
        #1 check(16'({timer_a_ff_out, timer_b_ff_out}), 16'h0001);
        wait_irq(1'b1, t1);
        wr(OFF_IRQ_STAT, 8'h03);
        wait_irq(1'b0, t2);
        wait_irq(1'b1, t2);
        check(16'(t2 - t1), 16'd260);
        rd(OFF_IRQ_STAT);
        check(16'(rd_v), 16'h0002);
        wr(OFF_CTL_B, 8'h94);
        wrap_up();
    end
endmodule
